// >>> css_sequencer.sv
// Clock source sequencer: oscillator, PLL and master clock control over APB.
`timescale 1ns/100ps
module css_sequencer
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic backup_power_good,
    input wire css_pkg::css_apb_req_t apb_req,
    output css_pkg::css_apb_rsp_t apb_rsp,
    output css_pkg::css_clk_ctrl_t clk_ctrl,
    output logic irq
);
    import css_pkg::*;

    // ======================================================================
    // State
    typedef enum logic [2:0]
    {
        SQ_IDLE = 3'b000,
        SQ_XT_START = 3'b001,
        SQ_SEL_SWITCH = 3'b010,
        SQ_PLL_LOCK = 3'b011,
        SQ_MCK_SWITCH = 3'b100
    } css_seq_t;

    typedef struct packed
    {
        logic [31:0] mor;
        logic [31:0] pll;
        logic [31:0] mck;
        logic xtal_stable;
        logic pll_locked;
        logic mck_ready;
        logic sel_done;
        logic slow_xtal;
        logic slow_valid;
        logic [13:0] slow_cnt;
        logic bkp_s1;
        logic bkp_s2;
        logic [31:0] irq_status;
        logic [31:0] irq_mask;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        logic [2:0] sw_cnt;
        logic sw_busy;
        logic pll_pending;
    } css_state_t;

    css_state_t st;
    css_state_t next_st;
    logic tmr_start;
    logic [19:0] tmr_count;
    logic tmr_done;
    logic wr_stb;
    logic rd_stb;
    logic [31:0] status_word;
    logic [31:0] events;
    logic [31:0] supply_status_register;

    css_timer u_timer
    (
        .clk(clk),
        .sys_rst(sys_rst),
        .start(tmr_start),
        .count(tmr_count),
        .done(tmr_done)
    );

    // ======================================================================
    // Bus decode
    // Slave answers one cycle into the access phase: one wait state per access.
    assign wr_stb = apb_req.psel && apb_req.penable && apb_req.pwrite && !st.pready;
    assign rd_stb = apb_req.psel && apb_req.penable && !apb_req.pwrite && !st.pready;

    always_comb
    begin
        status_word = '0;
        status_word[ST_XTAL_STABLE] = st.xtal_stable;
        status_word[ST_PLL_LOCKED] = st.pll_locked;
        status_word[ST_MCK_READY] = st.mck_ready;
        status_word[ST_SEL_DONE] = st.sel_done;
        status_word[ST_RC_READY] = st.mor[MOR_RC_EN_BIT];
        supply_status_register = '0;
        supply_status_register[SUPPLY_STATUS_REGISTER_SLOW_SRC_BIT] = st.slow_xtal; // [RQ3]
        supply_status_register[SUPPLY_STATUS_REGISTER_SLOW_VALID_BIT] = st.slow_valid;
    end

    // ======================================================================
    // Sequencing and registers
    always_comb
    begin
        logic mor_key_ok;
        logic supply_controller_key_ok;
        mor_key_ok = 1'b0;
        supply_controller_key_ok = 1'b0;
        next_st = st;
        events = '0;
        tmr_start = 1'b0;
        tmr_count = '0;
        next_st.bkp_s1 = backup_power_good;
        next_st.bkp_s2 = st.bkp_s1;
        next_st.pready = 1'b0;
        next_st.pslverr = 1'b0;

        // Slow RC runs as soon as backup power is seen; valid after its start time.
        if (!st.bkp_s2)
        begin
            next_st.slow_cnt = '0;
            next_st.slow_valid = 1'b0;
            next_st.slow_xtal = 1'b0;
        end
        else if (!st.slow_valid)
        begin
            if (st.slow_cnt == 14'(SLOW_VALID_CYC - 1))
                next_st.slow_valid = 1'b1; // [RQ2]
            else
                next_st.slow_cnt = st.slow_cnt + 14'h1;
        end

        // Oscillator startup counter expires: crystal is stable.
        // While a PLL lock is pending, the timer's done event goes to the PLL lock, not the crystal.
        if (tmr_done && !st.pll_pending)
        begin
            next_st.xtal_stable = 1'b1; // [RQ5]
            events[ST_XTAL_STABLE] = 1'b1;
        end
        if (tmr_done && st.pll_pending)
        begin
            next_st.pll_pending = 1'b0;
            next_st.pll_locked = 1'b1; // [RQ9]
            events[ST_PLL_LOCKED] = 1'b1;
        end

        // Short fixed-length glitch-free switch for source and master clock.
        if (st.sw_busy)
        begin
            if (st.sw_cnt == 3'(SWITCH_CYC - 1))
            begin
                next_st.sw_busy = 1'b0;
                next_st.sw_cnt = '0;
                if (st.mor[MOR_SEL_BIT] && !st.sel_done)
                begin
                    next_st.sel_done = 1'b1; // [RQ7]
                    events[ST_SEL_DONE] = 1'b1;
                end
                if (!st.mck_ready)
                begin
                    next_st.mck_ready = 1'b1; // [RQ11]
                    events[ST_MCK_READY] = 1'b1;
                end
            end
            else
                next_st.sw_cnt = st.sw_cnt + 3'h1;
        end

        next_st.prdata = '0;
        if (rd_stb || wr_stb)
            next_st.pready = 1'b1;
        if (rd_stb)
        begin
            unique case (apb_req.paddr)
                OFF_MAIN_OSC: next_st.prdata = st.mor & 32'h01ff_ff37;
                OFF_PLL_CFG: next_st.prdata = st.pll;
                OFF_MCK: next_st.prdata = st.mck;
                OFF_PM_STATUS: next_st.prdata = status_word;
                OFF_SUPPLY_STATUS: next_st.prdata = supply_status_register;
                OFF_IRQ_STATUS: next_st.prdata = st.irq_status;
                OFF_IRQ_MASK: next_st.prdata = st.irq_mask;
                OFF_SUPPLY_CTRL: next_st.prdata = '0;
                default: next_st.pslverr = 1'b1;
            endcase
        end

        if (wr_stb)
        begin
            mor_key_ok = apb_req.pwdata[MOR_KEY_LSB +: 8] == MOR_KEY;
            supply_controller_key_ok = apb_req.pwdata[SUPPLY_CONTROLLER_KEY_LSB +: 8] == SUPPLY_CONTROLLER_KEY;
            unique case (apb_req.paddr)
                OFF_MAIN_OSC:
                begin
                    if (mor_key_ok) // [RQ13]
                    begin
                        next_st.mor = apb_req.pwdata; // [RQ4]
                        if (apb_req.pwdata[MOR_XT_EN_BIT] && !st.mor[MOR_XT_EN_BIT])
                        begin
                            next_st.xtal_stable = 1'b0;
                            tmr_start = 1'b1;
                            tmr_count = 20'(apb_req.pwdata[MOR_COUNT_LSB +: 8]) * 20'(STARTUP_UNIT_CYC);
                        end
                        if (!apb_req.pwdata[MOR_XT_EN_BIT])
                            next_st.xtal_stable = 1'b0;
                        if (apb_req.pwdata[MOR_SEL_BIT] != st.mor[MOR_SEL_BIT])
                        begin
                            next_st.sel_done = 1'b0;
                            next_st.sw_busy = 1'b1;
                            next_st.sw_cnt = '0;
                        end
                    end
                end
                OFF_PLL_CFG:
                begin
                    next_st.pll = apb_req.pwdata;
                    next_st.pll_locked = 1'b0;
                    next_st.pll_pending = apb_req.pwdata[PLL_MUL_LSB +: 8] != 8'h0;
                    tmr_start = apb_req.pwdata[PLL_MUL_LSB +: 8] != 8'h0;
                    tmr_count = 20'(apb_req.pwdata[PLL_COUNT_LSB +: 6]) * 20'(STARTUP_UNIT_CYC);
                end
                OFF_MCK:
                begin
                    next_st.mck = apb_req.pwdata;
                    next_st.mck_ready = 1'b0; // [RQ11]
                    next_st.sw_busy = 1'b1;
                    next_st.sw_cnt = '0;
                end
                OFF_SUPPLY_CTRL:
                begin
                    if (supply_controller_key_ok && apb_req.pwdata[SUPPLY_CONTROLLER_XTAL_SEL_BIT]) // [RQ13]
                        next_st.slow_xtal = st.bkp_s2; // [RQ3]
                end
                OFF_IRQ_STATUS: next_st.irq_status = st.irq_status & ~apb_req.pwdata;
                OFF_IRQ_MASK: next_st.irq_mask = apb_req.pwdata;
                OFF_PM_STATUS, OFF_SUPPLY_STATUS: ;
                default: next_st.pslverr = 1'b1;
            endcase
        end
        // Set wins over a simultaneous write-one clear.
        next_st.irq_status = next_st.irq_status | events;
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            st <= '0;
            st.mor <= MOR_RESET; // [RQ1]
            st.mck <= MCK_RESET;
            st.mck_ready <= 1'b1;
        end
        else
            st <= next_st;
    end

    // ======================================================================
    // Outputs
    assign apb_rsp.prdata = st.prdata;
    assign apb_rsp.pready = st.pready;
    assign apb_rsp.pslverr = st.pslverr;
    assign irq = |(st.irq_status & st.irq_mask);

    always_comb
    begin
        clk_ctrl.main_rc_osc_enable = st.mor[MOR_RC_EN_BIT];
        clk_ctrl.main_xtal_osc_enable = st.mor[MOR_XT_EN_BIT] | st.mor[MOR_XT_BYPASS_BIT]; // [RQ6]
        clk_ctrl.main_source_select = st.sel_done; // [RQ7]
        clk_ctrl.rc_freq = st.mor[MOR_RC_FREQ_LSB +: 2]; // [RQ6]
        clk_ctrl.slow_xtal_select = st.slow_xtal;
        clk_ctrl.slow_valid = st.slow_valid;
        // Source follows the MCK register at once, before ready is set; prescaler is already applied. [RQ10]
        clk_ctrl.master_src = st.mck[MCK_CSS_LSB +: 2];
        clk_ctrl.prescale_half = st.mck[MCK_PRES_LSB]; // [RQ12]
        clk_ctrl.pll_multiplier = st.pll[PLL_MUL_LSB +: 8] + 8'h1; // [RQ8]
        clk_ctrl.pll_divider = st.pll[PLL_DIV_LSB +: 8]; // [RQ8]
    end
endmodule

// >>> css_pkg.sv
// Package of constants and carrier types for the clock source sequencer.
// ==========================================================================
// Overview of operation
// [RQ1] Reset runs core from fast RC 4MHz.
// [RQ2] Backup power: slow RC enabled, valid ~100us.
// [RQ3] Key 0xA5 write selects slow crystal; status shows.
// [RQ4] Key 0x37 main oscillator write starts oscillators.
// [RQ5] Crystal stable flag after startup count expires; not set if a PLL lock is pending when the shared timer ends.
// [RQ6] Main source: RC 4/8/12MHz or bypassable crystal.
// [RQ7] Source select switches to crystal, done flag.
// [RQ8] PLL divides input, multiplies by field plus one.
// [RQ9] PLL write, lock flag after lock time.
// [RQ10] Software sets prescaler before choosing PLL source.
// [RQ11] Each master clock write clears then sets ready.
// [RQ12] Prescaler divides selected clock by two.
// [RQ13] Writes with wrong key are ignored.
// ==========================================================================
package css_pkg;
    // ======================================================================
    // Register map
    localparam logic [7:0] OFF_MAIN_OSC = 8'h00;
    localparam logic [7:0] OFF_PLL_CFG = 8'h04;
    localparam logic [7:0] OFF_MCK = 8'h08;
    localparam logic [7:0] OFF_PM_STATUS = 8'h0c;
    localparam logic [7:0] OFF_SUPPLY_CTRL = 8'h10;
    localparam logic [7:0] OFF_SUPPLY_STATUS = 8'h14;
    localparam logic [7:0] OFF_IRQ_STATUS = 8'h18;
    localparam logic [7:0] OFF_IRQ_MASK = 8'h1c;
    // ======================================================================
    // Fields
    localparam int MOR_RC_EN_BIT = 0;
    localparam int MOR_XT_EN_BIT = 1;
    localparam int MOR_XT_BYPASS_BIT = 2;
    localparam int MOR_RC_FREQ_LSB = 4;
    localparam int MOR_COUNT_LSB = 8;
    localparam int MOR_KEY_LSB = 16;
    localparam int MOR_SEL_BIT = 24;
    localparam logic [7:0] MOR_KEY = 8'h37;
    localparam int SUPPLY_CONTROLLER_XTAL_SEL_BIT = 3;
    localparam int SUPPLY_CONTROLLER_KEY_LSB = 24;
    localparam logic [7:0] SUPPLY_CONTROLLER_KEY = 8'ha5;
    localparam int SUPPLY_STATUS_REGISTER_SLOW_SRC_BIT = 7;
    localparam int SUPPLY_STATUS_REGISTER_SLOW_VALID_BIT = 0;
    localparam int PLL_MUL_LSB = 16;
    localparam int PLL_COUNT_LSB = 8;
    localparam int PLL_DIV_LSB = 0;
    localparam int MCK_CSS_LSB = 0;
    localparam int MCK_PRES_LSB = 4;
    // Status / interrupt bit positions (same layout in both registers).
    localparam int ST_XTAL_STABLE = 0;
    localparam int ST_PLL_LOCKED = 1;
    localparam int ST_MCK_READY = 3;
    localparam int ST_SEL_DONE = 16;
    localparam int ST_RC_READY = 17;
    // ======================================================================
    // Reset values and timing
    localparam logic [31:0] MOR_RESET = 32'h0000_0001;
    localparam logic [31:0] MCK_RESET = 32'h0000_0001;
    localparam logic [1:0] RC_4MHZ = 2'h0;
    localparam int CLK_MHZ = 100;
    localparam int SLOW_VALID_US = 100;
    localparam int SLOW_VALID_CYC = SLOW_VALID_US * CLK_MHZ;
    localparam int STARTUP_UNIT_CYC = 8;
    localparam int SWITCH_CYC = 4;
    typedef enum logic [1:0]
    {
        CSS_SLOW = 2'b00,
        CSS_MAIN = 2'b01,
        CSS_PLL = 2'b10,
        CSS_RSVD = 2'b11
    } css_src_t;
    typedef struct packed
    {
        logic [7:0] paddr;
        logic psel;
        logic penable;
        logic pwrite;
        logic [31:0] pwdata;
    } css_apb_req_t;
    typedef struct packed
    {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } css_apb_rsp_t;
    typedef struct packed
    {
        logic main_rc_osc_enable;
        logic main_xtal_osc_enable;
        logic main_source_select;
        logic [1:0] rc_freq;
        logic slow_xtal_select;
        logic slow_valid;
        logic [1:0] master_src;
        logic prescale_half;
        logic [7:0] pll_multiplier;
        logic [7:0] pll_divider;
    } css_clk_ctrl_t;
endpackage

// >>> css_timer.sv
// Down counter that signals done after a programmed number of cycles.
`timescale 1ns/100ps
module css_timer
    import css_pkg::*;
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic start,
    input wire logic [19:0] count,
    output logic done
);
    typedef struct packed
    {
        logic [19:0] cnt;
        logic busy;
        logic done;
    } css_tmr_state_t;
    css_tmr_state_t st;
    css_tmr_state_t next_st;

    always_comb
    begin
        next_st = st;
        next_st.done = 1'b0;
        if (start)
        begin
            next_st.cnt = (count == 20'h0) ? 20'h1 : count;
            next_st.busy = 1'b1;
        end
        else if (st.busy)
        begin
            if (st.cnt == 20'h1)
            begin
                next_st.busy = 1'b0;
                next_st.done = 1'b1;
            end
            next_st.cnt = st.cnt - 20'h1;
        end
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
            st <= '0;
        else
            st <= next_st;
    end

    assign done = st.done;
endmodule

// >>> css_props.sv
// Concurrent checks on the ports of the clock source sequencer.
`timescale 1ns/100ps
module css_props
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic backup_power_good,
    input wire css_pkg::css_apb_req_t apb_req,
    input wire css_pkg::css_apb_rsp_t apb_rsp,
    input wire css_pkg::css_clk_ctrl_t clk_ctrl,
    input wire logic irq
);
    import css_pkg::*;
    logic [15:0] bp_cnt;
    logic [1:0] want_css;
    logic wr_done;
    logic [31:0] d;
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    assign d = apb_req.pwdata;
    assign wr_done = apb_req.psel && apb_req.penable && apb_rsp.pready && apb_req.pwrite;
    // ======================================================================
    // Helper state
    // The counter saturates so that a long run never wraps into the early window.
    always_ff @(posedge clk)
    begin
        if (sys_rst || !backup_power_good)
            bp_cnt <= 16'h0000;
        else if (bp_cnt != 16'hffff)
            bp_cnt <= bp_cnt + 16'h0001;
        if (wr_done && apb_req.paddr == OFF_MCK)
            want_css <= d[1:0];
    end
    // ======================================================================
    // Properties
    property p_reset_rc;
        $fell(sys_rst) |-> clk_ctrl.main_rc_osc_enable && clk_ctrl.rc_freq == RC_4MHZ && clk_ctrl.master_src == CSS_MAIN;
    endproperty
    a_reset_rc: assert property (p_reset_rc) else $error("reset clock source wrong");
    property p_mor_write;
        wr_done && apb_req.paddr == OFF_MAIN_OSC && d[23:16] == MOR_KEY |=> clk_ctrl.main_rc_osc_enable == $past(d[0])
            && clk_ctrl.main_xtal_osc_enable == ($past(d[1]) | $past(d[2])) && clk_ctrl.rc_freq == $past(d[5:4]);
    endproperty
    a_mor_write: assert property (p_mor_write) else $error("oscillator write not applied");
    property p_mor_badkey;
        wr_done && apb_req.paddr == OFF_MAIN_OSC && d[23:16] != MOR_KEY |=>
            clk_ctrl.main_xtal_osc_enable == $past(clk_ctrl.main_xtal_osc_enable, 3) && $stable(clk_ctrl.rc_freq);
    endproperty
    a_mor_badkey: assert property (p_mor_badkey) else $error("oscillator write without key applied");
    property p_supply_controller_sel;
        wr_done && apb_req.paddr == OFF_SUPPLY_CTRL && d[31:24] == SUPPLY_CONTROLLER_KEY && d[3] |=> ##[0:3] clk_ctrl.slow_xtal_select;
    endproperty
    a_supply_controller_sel: assert property (p_supply_controller_sel) else $error("slow crystal not selected");
    property p_supply_controller_badkey;
        wr_done && apb_req.paddr == OFF_SUPPLY_CTRL && d[31:24] != SUPPLY_CONTROLLER_KEY |=>
            clk_ctrl.slow_xtal_select == $past(clk_ctrl.slow_xtal_select, 3);
    endproperty
    a_supply_controller_badkey: assert property (p_supply_controller_badkey) else $error("supply write without key applied");
    property p_src_sel;
        wr_done && apb_req.paddr == OFF_MAIN_OSC && d[23:16] == MOR_KEY && d[24] |=> ##[0:7] clk_ctrl.main_source_select;
    endproperty
    a_src_sel: assert property (p_src_sel) else $error("main source not switched");
    property p_pll;
        wr_done && apb_req.paddr == OFF_PLL_CFG |=> clk_ctrl.pll_multiplier == $past(d[23:16]) + 8'h01
            && clk_ctrl.pll_divider == $past(d[7:0]);
    endproperty
    a_pll: assert property (p_pll) else $error("pll ratio wrong");
    property p_mck;
        wr_done && apb_req.paddr == OFF_MCK |=> ##[0:7] clk_ctrl.master_src == want_css;
    endproperty
    a_mck: assert property (p_mck) else $error("master source not switched");
    property p_slow_early;
        bp_cnt != 16'h0000 && bp_cnt < SLOW_VALID_CYC - 100 |-> !clk_ctrl.slow_valid;
    endproperty
    a_slow_early: assert property (p_slow_early) else $error("slow clock valid too early");
    property p_slow_late;
        bp_cnt > SLOW_VALID_CYC + 20 |-> clk_ctrl.slow_valid;
    endproperty
    a_slow_late: assert property (p_slow_late) else $error("slow clock valid too late");
    c_mck: cover property (wr_done && apb_req.paddr == OFF_MCK);
    c_irq: cover property ($rose(irq));
    c_slow: cover property ($rose(clk_ctrl.slow_valid));
endmodule
bind css_sequencer css_props u_props (.clk(clk), .sys_rst(sys_rst), .backup_power_good(backup_power_good),
    .apb_req(apb_req), .apb_rsp(apb_rsp), .clk_ctrl(clk_ctrl), .irq(irq));

// >>> tb.sv
// Self-checking testbench of the clock source sequencer.
`timescale 1ns/100ps
module tb;
    import css_pkg::*;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic bpg = 1'b0;
    css_apb_req_t req = '0;
    css_apb_rsp_t rsp;
    css_clk_ctrl_t cc;
    css_clk_ctrl_t ccs;
    logic irq;
    logic irqs;
    int n_mismatch = 0;
    int comparisons = 0;
    int seed = 32'h8696d409;
    logic [31:0] rd;
    logic er;
    int n;
    logic [7:0] cnt;
    logic [7:0] mul;
    logic [7:0] dv;
    logic [1:0] f;
    always #5 clk = ~clk;
    // Clock controls and irq are copied at the falling edge so that reads of them at the rising edge never race the design.
    always @(negedge clk) ccs = cc;
    always @(negedge clk) irqs = irq;
    css_sequencer DUT (.clk(clk), .sys_rst(sys_rst), .backup_power_good(bpg), .apb_req(req), .apb_rsp(rsp),
        .clk_ctrl(cc), .irq(irq));
    // ======================================================================
    // Tasks
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
        int k;
        k = 0;
        req.paddr <= a;
        req.pwrite <= w;
        req.pwdata <= d;
        req.psel <= 1'b1;
        @(posedge clk);
        req.penable <= 1'b1;
        @(posedge clk);
        while (rsp.pready !== 1'b1 && k < 20)
        begin
            @(posedge clk);
            k++;
        end
        rd = rsp.prdata;
        er = rsp.pslverr;
        if (k == 20)
            chk("pready", 32'h1, 32'h0);
        req.psel <= 1'b0;
        req.penable <= 1'b0;
        @(posedge clk);
    endtask
    task automatic poll(input logic [7:0] a, input int b);
        int c;
        c = 0;
        rd = 32'h0;
        while (rd[b] !== 1'b1 && c < 400)
        begin
            apb(a, 1'b0, 32'h0);
            c++;
        end
    endtask
    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // ======================================================================
    // Watchdog
    initial
    begin
        repeat (30000) @(posedge clk);
        n_mismatch++;
        print_verdict();
    end
    // ======================================================================
    // Tests
    initial
    begin
        repeat (16) @(posedge clk);
        sys_rst <= 1'b0;
        bpg <= 1'b1;
        repeat (2) @(posedge clk);
        chk("reset ctrl", {27'h0, 1'b1, RC_4MHZ, CSS_MAIN}, {27'h0, ccs.main_rc_osc_enable, ccs.rc_freq, ccs.master_src});
        apb(OFF_MAIN_OSC, 1'b0, 32'h0);
        chk("main osc reset", MOR_RESET, rd);
        apb(OFF_MCK, 1'b0, 32'h0);
        chk("mck reset", MCK_RESET, rd);
        apb(OFF_PM_STATUS, 1'b0, 32'h0);
        chk("mck ready reset", 32'h1, 32'(rd[ST_MCK_READY]));
        chk("irq reset", 32'h0, 32'(irqs));
        apb(8'h20, 1'b0, 32'h0);
        chk("unmapped error", 32'h1, 32'(er));
        $display("test reset done");
        apb(OFF_MAIN_OSC, 1'b1, 32'h0000_0306);
        apb(OFF_MAIN_OSC, 1'b0, 32'h0);
        chk("bad key osc", MOR_RESET, rd);
        apb(OFF_SUPPLY_CTRL, 1'b1, {8'h5a, 24'h8});
        chk("bad key slow", 32'h0, 32'(ccs.slow_xtal_select));
        $display("test keys done");
        for (int i = 0; i < 3; i++)
        begin
            f = i[1:0];
            apb(OFF_MAIN_OSC, 1'b1, {8'h00, MOR_KEY, 8'h00, 2'h0, f, 4'h1});
            chk("rc freq", 32'(f), 32'(ccs.rc_freq));
        end
        $display("test rc done");
        apb(OFF_IRQ_MASK, 1'b1, 32'h1);
        cnt = 8'h02 + 8'({$random(seed)} % 3);
        apb(OFF_MAIN_OSC, 1'b1, {8'h00, MOR_KEY, cnt, 8'h03});
        chk("osc enables", 32'h3, {30'h0, ccs.main_xtal_osc_enable, ccs.main_rc_osc_enable});
        apb(OFF_PM_STATUS, 1'b0, 32'h0);
        chk("stable early", 32'h0, 32'(rd[ST_XTAL_STABLE]));
        poll(OFF_PM_STATUS, ST_XTAL_STABLE);
        chk("stable", 32'h1, 32'(rd[ST_XTAL_STABLE]));
        chk("irq set", 32'h1, 32'(irqs));
        apb(OFF_IRQ_STATUS, 1'b1, 32'h1);
        chk("irq clear", 32'h0, 32'(irqs));
        $display("test oscillator done");
        apb(OFF_MAIN_OSC, 1'b1, {7'h0, 1'b1, MOR_KEY, cnt, 8'h03});
        poll(OFF_PM_STATUS, ST_SEL_DONE);
        chk("select done", 32'h1, 32'(rd[ST_SEL_DONE]));
        chk("source select", 32'h1, 32'(ccs.main_source_select));
        $display("test select done");
        apb(OFF_IRQ_MASK, 1'b1, 32'h0);
        repeat (3)
        begin
            mul = 8'h01 + 8'({$random(seed)} % 200);
            dv = 8'h01 + 8'({$random(seed)} % 255);
            apb(OFF_PLL_CFG, 1'b1, {8'h00, mul, 2'h0, 6'h03, dv});
            chk("pll ratio", {16'h0, mul + 8'h01, dv}, {16'h0, ccs.pll_multiplier, ccs.pll_divider});
            poll(OFF_PM_STATUS, ST_PLL_LOCKED);
            chk("pll lock", 32'h1, 32'(rd[ST_PLL_LOCKED]));
        end
        chk("irq masked", 32'h0, 32'(irqs));
        $display("test pll done");
        apb(OFF_MCK, 1'b1, {25'h0, 3'h1, 2'h0, CSS_MAIN});
        poll(OFF_PM_STATUS, ST_MCK_READY);
        chk("prescale main", {29'h0, 1'b1, CSS_MAIN}, {29'h0, ccs.prescale_half, ccs.master_src});
        apb(OFF_MCK, 1'b1, {25'h0, 3'h1, 2'h0, CSS_PLL});
        poll(OFF_PM_STATUS, ST_MCK_READY);
        chk("mck ready", 32'h1, 32'(rd[ST_MCK_READY]));
        chk("pll source", {29'h0, 1'b1, CSS_PLL}, {29'h0, ccs.prescale_half, ccs.master_src});
        $display("test master clock done");
        chk("slow early", 32'h0, 32'(ccs.slow_valid));
        repeat (10200) @(posedge clk);
        apb(OFF_SUPPLY_STATUS, 1'b0, 32'h0);
        chk("slow valid", 32'h1, 32'(rd[SUPPLY_STATUS_REGISTER_SLOW_VALID_BIT]));
        apb(OFF_SUPPLY_CTRL, 1'b1, {SUPPLY_CONTROLLER_KEY, 24'h8});
        poll(OFF_SUPPLY_STATUS, SUPPLY_STATUS_REGISTER_SLOW_SRC_BIT);
        chk("slow source", 32'h1, 32'(rd[SUPPLY_STATUS_REGISTER_SLOW_SRC_BIT]));
        chk("slow select", 32'h1, 32'(ccs.slow_xtal_select));
        $display("test slow clock done");
        sys_rst <= 1'b1;
        repeat (2) @(posedge clk);
        sys_rst <= 1'b0;
        repeat (2) @(posedge clk);
        chk("reset again", {27'h0, 1'b1, RC_4MHZ, CSS_MAIN}, {27'h0, ccs.main_rc_osc_enable, ccs.rc_freq, ccs.master_src});
        chk("slow cleared", 32'h0, 32'(ccs.slow_valid));
        apb(OFF_MAIN_OSC, 1'b0, 32'h0);
        chk("main osc reset again", MOR_RESET, rd);
        $display("test reset again done");
        print_verdict();
    end
endmodule
